// ### logic/pcd_pkg.sv
// Package with register map, field positions and reset values of the PLL controller.
`default_nettype none
package pcd_pkg;

	// Register bus and field widths.
	localparam int unsigned ADDR_W = 10;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned MULT_W = 5;
	localparam int unsigned RATIO_W = 3;

	// Byte offsets of the registers inside the controller window.
	localparam logic [9:0] OFF_PLL_CONTROL = 10'h100;
	localparam logic [9:0] OFF_MULT_SELECT = 10'h110;
	localparam logic [9:0] OFF_PRE_DIVIDER = 10'h114;
	localparam logic [9:0] OFF_DIVIDER_TWO = 10'h11C;
	localparam logic [9:0] OFF_GO_COMMAND = 10'h138;

	// Bit positions inside pll_control.
	localparam int unsigned CTL_MODE_BIT = 0;
	localparam int unsigned CTL_PWRDN_BIT = 1;
	localparam int unsigned CTL_RST_BIT = 3;
	localparam int unsigned CTL_DIS_BIT = 4;
	localparam int unsigned CTL_SRC_BIT = 5;

	// Bits 7-6 of pll_control always read as one.
	localparam logic [31:0] CTL_FIXED_ONES = 32'h0000_00C0;

	// Divider enable flag position and go command bit position.
	localparam int unsigned DIV_EN_BIT = 15;
	localparam int unsigned GO_BIT = 0;

	// Values after reset.
	localparam logic CTL_MODE_RST = 1'h0;
	localparam logic CTL_PWRDN_RST = 1'h0;
	localparam logic CTL_RST_RST = 1'h1;
	localparam logic CTL_DIS_RST = 1'h0;
	localparam logic CTL_SRC_RST = 1'h1;
	localparam logic [4:0] MULT_RST = 5'h13;
	localparam logic [2:0] PRE_RATIO_RST = 3'h0;
	localparam logic [2:0] DIV2_RATIO_RST = 3'h3;
	localparam logic [2:0] CNT_RST = 3'h0;

	// Address match, used by every register decode.
	function automatic logic addr_hit(input logic [9:0] addr, input logic [9:0] off);
		addr_hit = (addr == off);
	endfunction

endpackage
`default_nettype wire

// ### logic/pcd_div_if.sv
// Interface that carries a divider's ratio, enable and ticks.
`timescale 1ns/1ps
`default_nettype none
interface pcd_div_if;
	logic en;
	logic [2:0] ratio;
	logic tick_in;
	logic tick_out;

	// The controller feeds the divider and reads its output tick.
	modport ctrl (output en, output ratio, output tick_in, input tick_out);
	modport div (input en, input ratio, input tick_in, output tick_out);
endinterface
`default_nettype wire

// ### logic/pcd_clk_div.sv
// Programmable divide-by-(ratio+1) tick divider.
`timescale 1ns/1ps
`default_nettype none
module pcd_clk_div (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	pcd_div_if.div dv
);
	logic [2:0] cnt_q;
	logic [2:0] cnt_d;
	logic tick_q;
	logic wrap;

	// A count at or past the ratio wraps, so a ratio lowered mid-count
	// never lets the counter run the long way round.
	assign wrap = (cnt_q >= dv.ratio);
	assign cnt_d = wrap ? pcd_pkg::CNT_RST : 3'(cnt_q + 3'h1);

	// Count source ticks and emit one output tick per ratio+1 of them.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= pcd_pkg::CNT_RST;
			tick_q <= 1'b0;
		end else begin
			tick_q <= dv.en && dv.tick_in && wrap;
			if (dv.en && dv.tick_in) begin
				cnt_q <= cnt_d;
			end
		end
	end

	assign dv.tick_out = tick_q;
endmodule
`default_nettype wire

// ### logic/pcd_pll_ctrl.sv
// PLL controller: control register, multiplier, pre-divider and system clock two divider.
`timescale 1ns/1ps
`default_nettype none
module pcd_pll_ctrl #(
	parameter bit MEM_CTRL = 1'b0
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [9:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	input wire logic ref_clk_tick_i,
	input wire logic pll_out_tick_i,
	output logic pll_mode_select_o,
	output logic pll_power_down_o,
	output logic pll_reset_assert_o,
	output logic pll_output_disable_o,
	output logic [4:0] multiplier_select_o,
	output logic [2:0] pre_divider_ratio_o,
	output logic pre_divider_tick_o,
	output logic div_source_tick_o,
	output logic system_clock_two_tick_o
);

	// Address decode for each register.
	wire hit_ctl = pcd_pkg::addr_hit(reg_addr_i, pcd_pkg::OFF_PLL_CONTROL);
	wire hit_mult = pcd_pkg::addr_hit(reg_addr_i, pcd_pkg::OFF_MULT_SELECT);
	wire hit_pre = pcd_pkg::addr_hit(reg_addr_i, pcd_pkg::OFF_PRE_DIVIDER);
	wire hit_div2 = pcd_pkg::addr_hit(reg_addr_i, pcd_pkg::OFF_DIVIDER_TWO);
	wire hit_go = pcd_pkg::addr_hit(reg_addr_i, pcd_pkg::OFF_GO_COMMAND);

	// Write strobes per register.
	wire wr_ctl = reg_wr_i && hit_ctl;
	wire wr_mult = reg_wr_i && hit_mult;
	wire wr_pre = reg_wr_i && hit_pre;
	wire wr_div2 = reg_wr_i && hit_div2;
	wire wr_go = reg_wr_i && hit_go;

	// Control register state.
	logic mode_q;
	logic pwrdn_q;
	logic prst_q;
	logic dis_q;
	logic src_gate_q;
	logic mode_d;

	// Multiplier, pre-divider and divider two state.
	logic [4:0] mult_q;
	logic [2:0] pre_ratio_q;
	logic [2:0] div2_pend_q;
	logic [2:0] div2_act_q;
	logic go_q;
	logic src_tick_q;
	logic [31:0] rdata_q;

	// The mode bit only follows a write once the source gate has already
	// been cleared by an earlier write; clearing both in one write leaves
	// the mode unchanged, so software must use two writes.
	assign mode_d = (wr_ctl && !src_gate_q) ? reg_wdata_i[pcd_pkg::CTL_MODE_BIT] : mode_q;

	// Control register flops.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_q <= pcd_pkg::CTL_MODE_RST;
			pwrdn_q <= pcd_pkg::CTL_PWRDN_RST;
			prst_q <= pcd_pkg::CTL_RST_RST;
			dis_q <= pcd_pkg::CTL_DIS_RST;
			src_gate_q <= pcd_pkg::CTL_SRC_RST;
		end else begin
			mode_q <= mode_d;
			if (wr_ctl) begin
				pwrdn_q <= reg_wdata_i[pcd_pkg::CTL_PWRDN_BIT];
				prst_q <= reg_wdata_i[pcd_pkg::CTL_RST_BIT];
				dis_q <= reg_wdata_i[pcd_pkg::CTL_DIS_BIT];
				src_gate_q <= reg_wdata_i[pcd_pkg::CTL_SRC_BIT];
			end
		end
	end

	// Multiplier field; the memory-clock instance keeps its reset value.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mult_q <= pcd_pkg::MULT_RST;
		end else if (wr_mult && !MEM_CTRL) begin
			mult_q <= reg_wdata_i[4:0];
		end
	end

	// Pre-divider ratio takes effect at once; it sits ahead of the PLL.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pre_ratio_q <= pcd_pkg::PRE_RATIO_RST;
		end else if (wr_pre) begin
			pre_ratio_q <= reg_wdata_i[2:0];
		end
	end

	// Divider two: a written ratio waits in the pending copy until go.
	// Holding it back keeps the running clock from glitching mid-period.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div2_pend_q <= pcd_pkg::DIV2_RATIO_RST;
			div2_act_q <= pcd_pkg::DIV2_RATIO_RST;
		end else begin
			if (wr_div2 && !MEM_CTRL) begin
				div2_pend_q <= reg_wdata_i[2:0];
			end
			if (go_q) begin
				div2_act_q <= div2_pend_q;
			end
		end
	end

	// Go bit: a one starts the load, a zero only clears; it completes in
	// one cycle, so a read normally sees it back at zero.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			go_q <= 1'b0;
		end else begin
			go_q <= wr_go && reg_wdata_i[pcd_pkg::GO_BIT];
		end
	end

	// Divider source follows the clock path choice.
	wire src_tick = mode_q ? pll_out_tick_i : ref_clk_tick_i;

	// Register the source tick so that both consumers see one flop edge.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			src_tick_q <= 1'b0;
		end else begin
			src_tick_q <= src_tick;
		end
	end

	// Pre-divider on the reference and divider two on the source tick.
	pcd_div_if pre_if ();
	pcd_div_if div2_if ();

	assign pre_if.en = 1'b1;
	assign pre_if.ratio = pre_ratio_q;
	assign pre_if.tick_in = ref_clk_tick_i;
	assign div2_if.en = !MEM_CTRL;
	assign div2_if.ratio = div2_act_q;
	assign div2_if.tick_in = src_tick_q;

	pcd_clk_div u_pre_div (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.dv(pre_if.div)
	);

	pcd_clk_div u_div_two (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.dv(div2_if.div)
	);

	// Read views of each register, reserved bits fixed.
	wire [31:0] rd_ctl = pcd_pkg::CTL_FIXED_ONES | {26'h0, src_gate_q, dis_q, prst_q, 1'b0,
		pwrdn_q, mode_q};
	wire [31:0] rd_mult = {27'h0, mult_q};
	wire [31:0] rd_pre = {16'h0, 1'b1, 12'h0, pre_ratio_q};
	wire [31:0] rd_div2 = MEM_CTRL ? 32'h0 : {16'h0, 1'b1, 12'h0, div2_pend_q};
	wire [31:0] rd_go = {31'h0, go_q};

	// Read select; an unmapped address answers zero.
	wire [31:0] rd_mux = hit_ctl ? rd_ctl :
		hit_mult ? rd_mult :
		hit_pre ? rd_pre :
		hit_div2 ? rd_div2 :
		hit_go ? rd_go : 32'h0;

	// Read data stand only in the cycle after the strobe.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q <= 32'h0;
		end else begin
			rdata_q <= reg_rd_i ? rd_mux : 32'h0;
		end
	end

	// Outputs toward the PLL macro and clock consumers.
	assign reg_rdata_o = rdata_q;
	assign pll_mode_select_o = mode_q;
	assign pll_power_down_o = pwrdn_q;
	assign pll_reset_assert_o = prst_q;
	assign pll_output_disable_o = dis_q;
	assign multiplier_select_o = mult_q;
	assign pre_divider_ratio_o = pre_ratio_q;
	assign pre_divider_tick_o = pre_if.tick_out;
	assign div_source_tick_o = src_tick_q;
	assign system_clock_two_tick_o = div2_if.tick_out;

	// Checks on the block's own outputs and on the active divider two ratio.
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	property p_gate_blocks_mode;
		wr_ctl && src_gate_q |=> pll_mode_select_o == $past(pll_mode_select_o);
	endproperty
	a_gate_blocks_mode: assert property (p_gate_blocks_mode) else $error("mode changed while gated");

	property p_mode_follows;
		wr_ctl && !src_gate_q |=> pll_mode_select_o == $past(reg_wdata_i[0]);
	endproperty
	a_mode_follows: assert property (p_mode_follows) else $error("mode bit not written");

	property p_disable;
		wr_ctl |=> pll_output_disable_o == $past(reg_wdata_i[4]);
	endproperty
	a_disable: assert property (p_disable) else $error("disable does not follow bit 4");

	property p_reset_pin;
		wr_ctl |=> pll_reset_assert_o == $past(reg_wdata_i[3]);
	endproperty
	a_reset_pin: assert property (p_reset_pin) else $error("reset does not follow bit 3");

	property p_pwrdn;
		!wr_ctl |=> $stable(pll_power_down_o);
	endproperty
	a_pwrdn: assert property (p_pwrdn) else $error("power-down moved without a write");

	property p_mult;
		wr_mult |=> multiplier_select_o == (MEM_CTRL ? $past(multiplier_select_o)
			: $past(reg_wdata_i[4:0]));
	endproperty
	a_mult: assert property (p_mult) else $error("multiplier write wrong");

	property p_go_only;
		!go_q |=> $stable(div2_act_q);
	endproperty
	a_go_only: assert property (p_go_only) else $error("divider two ratio moved without go");

	property p_src_sel;
		pll_mode_select_o && !pll_out_tick_i ##1 1'b1 |-> !div_source_tick_o;
	endproperty
	a_src_sel: assert property (p_src_sel) else $error("source tick not from PLL");

	property p_ctl_rsvd;
		reg_rd_i && hit_ctl |=> reg_rdata_o[7:6] == 2'h3 && reg_rdata_o[31:8] == 24'h0;
	endproperty
	a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("control reserved bits wrong");

	property p_pre_en;
		reg_rd_i && hit_pre |=> reg_rdata_o[15];
	endproperty
	a_pre_en: assert property (p_pre_en) else $error("pre-divider enable not one");

	// Write paths and read views that software relies on.
	property p_pwrdn_write;
		wr_ctl |=> pll_power_down_o == $past(reg_wdata_i[1]);
	endproperty
	a_pwrdn_write: assert property (p_pwrdn_write) else $error("power-down not written");

	property p_pre_ratio;
		wr_pre |=> pre_divider_ratio_o == $past(reg_wdata_i[2:0]);
	endproperty
	a_pre_ratio: assert property (p_pre_ratio) else $error("pre-divider ratio not written");

	property p_mult_rsvd;
		reg_rd_i && hit_mult |=> reg_rdata_o[31:5] == 27'h0;
	endproperty
	a_mult_rsvd: assert property (p_mult_rsvd) else $error("multiplier reserved bits wrong");

	property p_div2_view;
		reg_rd_i && hit_div2 && !MEM_CTRL |=> reg_rdata_o[15] && reg_rdata_o[14:3] == 12'h0;
	endproperty
	a_div2_view: assert property (p_div2_view) else $error("divider two enable not one");

	// The active ratio only ever takes the pending copy, and only after go.
	property p_go_load;
		go_q |=> div2_act_q == $past(div2_pend_q);
	endproperty
	a_go_load: assert property (p_go_load) else $error("go did not load divider two ratio");

	// A divider two tick must follow a source tick; a tick without one would
	// mean the divider had lost its source and runs free.
	property p_div2_src;
		system_clock_two_tick_o |-> $past(div_source_tick_o);
	endproperty
	a_div2_src: assert property (p_div2_src) else $error("divider two ticked without source");

	// The memory-clock instance never uses divider two.
	property p_div2_mem_idle;
		MEM_CTRL |-> !system_clock_two_tick_o;
	endproperty
	a_div2_mem_idle: assert property (p_div2_mem_idle) else $error("unused divider two ticked");

	// Main scenarios worth seeing.
	c_mode_on: cover property (wr_ctl && !src_gate_q && reg_wdata_i[0]);
	c_go_load: cover property (wr_div2 ##[1:20] wr_go && reg_wdata_i[0]);
	c_div2_tick: cover property (system_clock_two_tick_o && pll_mode_select_o);
	c_gated_try: cover property (wr_ctl && src_gate_q && reg_wdata_i[0]);

endmodule
`default_nettype wire

// ### verif/pcd_pll_model.sv
// Behavioural model of the PLL macro and of the reference clock source.
`timescale 1ns/1ps
`default_nettype none
module pcd_pll_model (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic pll_power_down_i,
	input wire logic pll_output_disable_i,
	input wire logic pll_reset_assert_i,
	output logic ref_clk_tick_o,
	output logic pll_out_tick_o
);
	logic run;
	// The macro output ticks only while powered, enabled and out of reset.
	assign run = !pll_power_down_i && !pll_output_disable_i && !pll_reset_assert_i;
	// Reference ticks every second cycle; the PLL is faster and ticks every cycle.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ref_clk_tick_o <= 1'b0;
			pll_out_tick_o <= 1'b0;
		end else begin
			ref_clk_tick_o <= !ref_clk_tick_o;
			pll_out_tick_o <= run;
		end
	end
endmodule
`default_nettype wire

// ### verif/pll_control_and_dividers_tb_top.sv
// Self-checking bench for the PLL controller, main and memory-clock instances.
`timescale 1ns/1ps
`default_nettype none
module pll_control_and_dividers_tb_top;
	typedef struct {logic [9:0] a; logic [31:0] w; logic [31:0] r; logic [3:0] o;} pcd_row_s;
	localparam int STAB_CYC = 20;
	logic clk_sys_i, rst_n_i, wr, rd, ref_t, pll_t, mode, pwr, prst, dis;
	logic pre_t, src_t, s2_t, s2_m;
	logic [9:0] addr;
	logic [31:0] wd, rdata, rdata_m, got, got_m;
	logic [4:0] mult;
	logic [2:0] pre;
	int miscompares, total_checks, c_pre, c_src, c_s2, c_m;
	pcd_row_s rows [7];

	pcd_pll_ctrl #(.MEM_CTRL(1'b0)) u_pcd_pll_ctrl (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
		.ref_clk_tick_i(ref_t), .pll_out_tick_i(pll_t), .pll_mode_select_o(mode),
		.pll_power_down_o(pwr), .pll_reset_assert_o(prst), .pll_output_disable_o(dis),
		.multiplier_select_o(mult), .pre_divider_ratio_o(pre), .pre_divider_tick_o(pre_t),
		.div_source_tick_o(src_t), .system_clock_two_tick_o(s2_t));
	// The memory-clock instance shares the bus; only its read data and divider are watched.
	pcd_pll_ctrl #(.MEM_CTRL(1'b1)) u_pcd_pll_ctrl_mem (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata_m),
		.ref_clk_tick_i(ref_t), .pll_out_tick_i(pll_t), .pll_mode_select_o(),
		.pll_power_down_o(), .pll_reset_assert_o(), .pll_output_disable_o(),
		.multiplier_select_o(), .pre_divider_ratio_o(), .pre_divider_tick_o(),
		.div_source_tick_o(), .system_clock_two_tick_o(s2_m));
	pcd_pll_model u_pcd_pll_model (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.pll_power_down_i(pwr), .pll_output_disable_i(dis), .pll_reset_assert_i(prst),
		.ref_clk_tick_o(ref_t), .pll_out_tick_o(pll_t));

	// Clock at 250 MHz.
	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = !clk_sys_i;
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Single-cycle write strobe.
	task automatic wrr(input logic [9:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		wr <= 1'b1;
		addr <= a;
		wd <= d;
		@(posedge clk_sys_i);
		wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe, so it is taken there.
	task automatic rdr(input logic [9:0] a);
		@(posedge clk_sys_i);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_sys_i);
		rd <= 1'b0;
		#1;
		got = rdata;
		got_m = rdata_m;
	endtask

	// Counts output pulses over a window; a periodic pulse gives an exact count.
	task automatic count(input int n);
		c_pre = 0;
		c_src = 0;
		c_s2 = 0;
		c_m = 0;
		repeat (n) begin
			@(posedge clk_sys_i);
			#1;
			c_pre += int'(pre_t === 1'b1);
			c_src += int'(src_t === 1'b1);
			c_s2 += int'(s2_t === 1'b1);
			c_m += int'(s2_m === 1'b1);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// Main sequence: table rows first, then the memory instance, then clock paths, then a second reset.
	initial begin
		{rst_n_i, wr, rd, addr, wd} = '0;
		rows = '{'{10'h100, 32'hFFFFFFFF, 32'h000000FA, 4'b0111},
			'{10'h100, 32'h00000000, 32'h000000C0, 4'b0000},
			'{10'h100, 32'h00000001, 32'h000000C1, 4'b1000},
			'{10'h110, 32'hFFFFFFEA, 32'h0000000A, 4'b1000},
			'{10'h114, 32'hFFFF0005, 32'h00008005, 4'b1000},
			'{10'h11C, 32'h00007FF1, 32'h00008001, 4'b1000},
			'{10'h200, 32'hFFFFFFFF, 32'h00000000, 4'b1000}};
		repeat (20) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		foreach (rows[i]) begin
			wrr(rows[i].a, rows[i].w);
			repeat (STAB_CYC) @(posedge clk_sys_i);
			rdr(rows[i].a);
			chk("reg", rows[i].r, got);
			chk("ctl", {28'h0, rows[i].o}, {28'h0, mode, pwr, prst, dis});
		end
		chk("mult_o", 32'h0A, {27'h0, mult});
		chk("pre_o", 32'h5, {29'h0, pre});
		$display("test rows done");
		wrr(10'h110, 32'h1F);
		rdr(10'h110);
		chk("mult", 32'h1F, got);
		chk("mem_mult", 32'h13, got_m);
		rdr(10'h11C);
		chk("mem_div2", 32'h0, got_m);
		$display("test memory instance done");
		count(48);
		chk("src_pll", 32'd48, c_src);
		chk("pre_t", 32'd4, c_pre);
		chk("s2_old", 32'd12, c_s2);
		chk("s2_mem", 32'd0, c_m);
		wrr(10'h138, 32'h0);
		count(48);
		chk("s2_go0", 32'd12, c_s2);
		wrr(10'h138, 32'h1);
		rdr(10'h138);
		chk("go_clr", 32'h0, got);
		repeat (4) @(posedge clk_sys_i);
		count(48);
		chk("s2_go1", 32'd24, c_s2);
		wrr(10'h100, 32'h0);
		repeat (4) @(posedge clk_sys_i);
		count(48);
		chk("src_byp", 32'd24, c_src);
		chk("s2_byp", 32'd12, c_s2);
		wrr(10'h100, 32'h11);
		repeat (4) @(posedge clk_sys_i);
		count(48);
		chk("src_dis", 32'd0, c_src);
		wrr(10'h100, 32'h3);
		repeat (4) @(posedge clk_sys_i);
		count(48);
		chk("src_pwrdn", 32'd0, c_src);
		$display("test clock paths done");
		@(posedge clk_sys_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		chk("rst_ctl", 32'h2, {28'h0, mode, pwr, prst, dis});
		chk("rst_mult_o", 32'h13, {27'h0, mult});
		rdr(10'h100);
		chk("rst_100", 32'hE8, got);
		rdr(10'h110);
		chk("rst_110", 32'h13, got);
		rdr(10'h114);
		chk("rst_114", 32'h8000, got);
		rdr(10'h11C);
		chk("rst_11C", 32'h8003, got);
		$display("test reset done");
		summarize();
	end
endmodule
`default_nettype wire
